// *** hims_defines.svh ***
`ifndef HIMS_DEFINES_SVH
`define HIMS_DEFINES_SVH
// Strap codes
`define HIMS_P1_8      4'h0
`define HIMS_P1_16     4'h1
`define HIMS_P1_9      4'h2
`define HIMS_P1_18     4'h3
`define HIMS_DSI       4'h4
`define HIMS_S3_BIDIR  4'h5
`define HIMS_S2LANE    4'h5
`define HIMS_S4_BIDIR  4'h6
`define HIMS_P2_16     4'h8
`define HIMS_P2_8      4'h9
`define HIMS_P2_18     4'hA
`define HIMS_P2_9      4'hB
`define HIMS_S3_SPLIT  4'hD
`define HIMS_S4_SPLIT  4'hE
// APB register byte offsets
`define HIMS_REG_MODE  12'h000
`define HIMS_REG_CTRL  12'h004
`define HIMS_REG_RXW   12'h008
`define HIMS_REG_TXW   12'h00C
`define HIMS_REG_STAT  12'h010
// Control fields
`define HIMS_CTRL_TE_BIT    0
`define HIMS_CTRL_2LANE_BIT 1
`define HIMS_STAT_RXV_BIT   0
`define HIMS_STAT_TXB_BIT   1
`define HIMS_RESET_CTRL     2'h0
`endif

// *** hims_pkg.sv ***
package hims_pkg;
  typedef enum logic [2:0] {HIMS_NONE, HIMS_PAR, HIMS_DSI_M, HIMS_SER3, HIMS_SER4, HIMS_SER2L} hims_kind_t;
  typedef struct packed {
    logic        is_data;
    logic [17:0] word;
  } hims_word_t;
endpackage

// *** hims_top.sv ***
// Overview of operation
// - IM3 low selects type-one parallel widths
// - IM3 high selects type-two shifted parallel pins
// - Code 0100 routes DSI pairs onto pads
// - Two-lane serial uses data pin and write
// - IM3 sets serial data pin direction
// - Serial input sampled on clock rising edge
// - Serial read bit driven on falling edge
// - Active-low hardware reset pin resets device; here it blocks the parallel and serial ports, not the DSI pad taps, and leaves the APB registers as they are
// - Chip select high blocks all interface activity; here the DSI pad taps still follow the pads
// - Data/command pin marks parallel words
// - Serial modes use DC pin as clock
// - Read strobe only active in parallel modes
// - Write strobe is enable or serial DC
// - Tearing sync output pulse provided
// - Four-line 8-bit serial has two variants
// - Three-line 9-bit serial has two variants
// - Host keeps DSI virtual channel zero
//
// Our own choices: the APB slave port and the placing of the registers.
`include "hims_defines.svh"
module hims_top
  import hims_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        hw_reset_low_i,
  input  wire logic [3:0]  interface_select_straps_i,
  input  wire logic        chip_select_low_i,
  input  wire logic        dc_or_serial_clock_pin_i,
  input  wire logic        read_strobe_low_i,
  input  wire logic        write_strobe_pin_i,
  input  wire logic [17:0] parallel_data_pins_i,
  output logic      [17:0] parallel_data_pins_o,
  output logic      [17:0] parallel_data_pins_oe_n_o,
  input  wire logic        serial_data_i,
  output logic             serial_data_o,
  output logic             serial_data_oe_n_o,
  output logic             serial_read_out_o,
  output logic             frame_sync_pulse_out_o,
  output logic [3:0]       hs_clock_pair_o,
  output logic [7:0]       hs_lane0_pair_o,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  // Pin synchronisers: straps, strobes and chip select come from the host domain
  logic [25:0] s1_q, s2_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 26'h3FFFFFF;
      s2_q <= 26'h3FFFFFF;
    end else if (clk_en_i) begin
      s1_q <= {hw_reset_low_i, interface_select_straps_i, chip_select_low_i, read_strobe_low_i,
               write_strobe_pin_i, parallel_data_pins_i};
      s2_q <= s1_q;
    end
  end
  wire        hwr_n  = s2_q[25];
  wire [3:0]  strap  = s2_q[24:21];
  wire        cs_n   = s2_q[20];
  wire        rd_n   = s2_q[19];
  wire        wr_s   = s2_q[18];
  wire [17:0] db_s   = s2_q[17:0];

  // Mode decode, used by datapath and status read
  function automatic hims_kind_t kind_of(input logic [3:0] c, input logic two_lane);
    unique case (c)
      `HIMS_P1_8, `HIMS_P1_16, `HIMS_P1_9, `HIMS_P1_18,
      `HIMS_P2_16, `HIMS_P2_8, `HIMS_P2_18, `HIMS_P2_9: kind_of = HIMS_PAR;
      `HIMS_DSI:      kind_of = HIMS_DSI_M;
      `HIMS_S3_BIDIR: kind_of = two_lane ? HIMS_SER2L : HIMS_SER3;
      `HIMS_S3_SPLIT: kind_of = HIMS_SER3;
      `HIMS_S4_BIDIR, `HIMS_S4_SPLIT: kind_of = HIMS_SER4;
      default:        kind_of = HIMS_NONE;
    endcase
  endfunction

  // Parallel gather: width and pin alignment per strap code
  function automatic logic [17:0] par_word(input logic [3:0] c, input logic [17:0] d);
    unique case (c)
      `HIMS_P1_8:  par_word = {10'h000, d[7:0]};
      `HIMS_P1_16: par_word = {2'h0, d[15:0]};
      `HIMS_P1_9:  par_word = {9'h000, d[8:0]};
      `HIMS_P2_16: par_word = {2'h0, d[17:10], d[8:1]};
      `HIMS_P2_8:  par_word = {10'h000, d[17:10]};
      `HIMS_P2_9:  par_word = {9'h000, d[17:9]};
      default:     par_word = d;                             // 18-bit
    endcase
  endfunction

  logic [1:0] ctrl_q;
  // DC level flops, declared early because the word capture reads them
  logic       dc_m_q;
  logic       dc_sync_q;
  wire hims_kind_t kind   = kind_of(strap, ctrl_q[`HIMS_CTRL_2LANE_BIT]);
  wire             split  = strap[3];
  wire             active = !cs_n && hwr_n;

  // Parallel write capture on write-strobe rising edge
  logic       wr_d1_q;
  hims_word_t rx_q;
  logic       rxv_q;
  wire        par_wr = (kind == HIMS_PAR) && active && wr_s && !wr_d1_q;
  wire        par_rd = (kind == HIMS_PAR) && active && !rd_n;

  // Serial link domain: dc pin is the serial clock in serial modes
  logic [8:0] sh_q;
  logic [3:0] cnt_q;
  logic       tog_q;
  logic [8:0] hold_q;
  wire        sclk   = dc_or_serial_clock_pin_i;
  wire        l_cs   = chip_select_low_i | !hw_reset_low_i;
  wire [3:0]  flen   = (kind == HIMS_SER3) ? 4'h9 : 4'h8;
  wire        lane2  = (kind == HIMS_SER2L);
  always_ff @(posedge sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q   <= 9'h000;
      cnt_q  <= 4'h0;
      tog_q  <= 1'b0;
      hold_q <= 9'h000;
    end else if (l_cs) begin
      cnt_q <= 4'h0;
    end else begin
      sh_q <= lane2 ? {sh_q[6:0], serial_data_i, write_strobe_pin_i}
                    : {sh_q[7:0], serial_data_i};
      if (cnt_q + (lane2 ? 4'h2 : 4'h1) >= flen) begin
        cnt_q  <= 4'h0;
        hold_q <= lane2 ? {1'b1, sh_q[5:0], serial_data_i, write_strobe_pin_i}
                : (kind == HIMS_SER3) ? {sh_q[7:0], serial_data_i}
                : {write_strobe_pin_i, sh_q[6:0], serial_data_i};
        tog_q  <= ~tog_q;
      end else begin
        cnt_q <= cnt_q + (lane2 ? 4'h2 : 4'h1);
      end
    end
  end

  // Serial read shift on falling edge
  logic [7:0] tsh_q;
  logic [7:0] txw_q;
  logic       sout_q;
  always_ff @(negedge sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tsh_q  <= 8'h00;
      sout_q <= 1'b0;
    end else if (l_cs) begin
      tsh_q <= txw_q;
    end else begin
      sout_q <= tsh_q[7];
      tsh_q  <= {tsh_q[6:0], 1'b0};
    end
  end

  // Toggle crossing of completed serial frames
  logic [2:0] tg_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tg_q <= 3'h0;
    end else if (clk_en_i) begin
      tg_q <= {tg_q[1:0], tog_q};
    end
  end
  wire ser_done = tg_q[2] ^ tg_q[1];

  // Receive word capture; set wins over a software clear
  wire rx_clr = psel && penable && !pwrite && (paddr == `HIMS_REG_RXW);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_d1_q <= 1'b1;
      rx_q    <= '0;
      rxv_q   <= 1'b0;
    end else if (clk_en_i) begin
      wr_d1_q <= wr_s;
      if (par_wr) begin
        rx_q  <= '{is_data: dc_sync_q, word: par_word(strap, db_s)};
        rxv_q <= 1'b1;
      end else if (ser_done) begin
        rx_q  <= '{is_data: hold_q[8], word: {10'h000, hold_q[7:0]}};
        rxv_q <= 1'b1;
      end else if (rx_clr) begin
        rxv_q <= 1'b0;
      end
    end
  end

  // DC level sync for parallel modes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dc_m_q    <= 1'b0;
      dc_sync_q <= 1'b0;
    end else if (clk_en_i) begin
      dc_m_q    <= dc_or_serial_clock_pin_i;
      dc_sync_q <= dc_m_q;
    end
  end

  // APB slave, zero wait states
  wire wr_en = psel && penable && pwrite;
  wire [31:0] rd_mux =
      (paddr == `HIMS_REG_MODE) ? {25'h0, kind, strap} :
      (paddr == `HIMS_REG_CTRL) ? {30'h0, ctrl_q} :
      (paddr == `HIMS_REG_RXW)  ? {13'h0, rx_q} :
      (paddr == `HIMS_REG_TXW)  ? {24'h0, txw_q} :
      (paddr == `HIMS_REG_STAT) ? {30'h0, 1'b0, rxv_q} : 32'h0;
  wire mapped = (paddr == `HIMS_REG_MODE) || (paddr == `HIMS_REG_CTRL) || (paddr == `HIMS_REG_RXW) ||
                (paddr == `HIMS_REG_TXW) || (paddr == `HIMS_REG_STAT);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q  <= `HIMS_RESET_CTRL;
      txw_q   <= 8'h00;
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en_i) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= rd_mux;
      if (wr_en && pready && paddr == `HIMS_REG_CTRL) ctrl_q <= pwdata[1:0];
      if (wr_en && pready && paddr == `HIMS_REG_TXW)  txw_q  <= pwdata[7:0];
    end
  end

  // Pad drivers: parallel read-back, DSI pad sharing, serial direction
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      parallel_data_pins_o      <= 18'h00000;
      parallel_data_pins_oe_n_o <= 18'h3FFFF;
      serial_data_o             <= 1'b0;
      serial_data_oe_n_o        <= 1'b1;
      serial_read_out_o         <= 1'b0;
      frame_sync_pulse_out_o    <= 1'b0;
      hs_clock_pair_o           <= 4'h0;
      hs_lane0_pair_o           <= 8'h00;
    end else if (clk_en_i) begin
      parallel_data_pins_o      <= {10'h000, txw_q};
      parallel_data_pins_oe_n_o <= par_rd ? 18'h00000 : 18'h3FFFF;
      hs_clock_pair_o           <= (kind == HIMS_DSI_M) ? {db_s[7:6], db_s[3:2]} : 4'h0;
      hs_lane0_pair_o           <= (kind == HIMS_DSI_M) ? {db_s[15:12], db_s[11:8]} : 8'h00;
      serial_data_o             <= sout_q;
      // In three- and four-line modes, turn the shared pin whenever a nonzero read byte is loaded and the chip is selected, host writes included
      serial_data_oe_n_o        <= !(active && !split && (kind == HIMS_SER3 || kind == HIMS_SER4) &&
                                     (txw_q != 8'h00));
      serial_read_out_o         <= split ? sout_q : 1'b0;
      frame_sync_pulse_out_o    <= ctrl_q[`HIMS_CTRL_TE_BIT];
    end
  end

  AST_TE_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i |=> frame_sync_pulse_out_o == $past(ctrl_q[`HIMS_CTRL_TE_BIT]))
    else $error("sync output mismatch");
  AST_CS_BLOCKS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_n |-> !par_wr) else $error("write taken while deselected");
  AST_RD_ONLY_PAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && kind != HIMS_PAR |=> &parallel_data_pins_oe_n_o) else $error("bus driven outside parallel");
  AST_RESERVED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    strap == 4'h7 |-> kind == HIMS_NONE) else $error("reserved code decoded");
  AST_DSI_SEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    strap == `HIMS_DSI |-> kind == HIMS_DSI_M) else $error("dsi not selected");
  AST_SPLIT_DIR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && split |=> serial_data_oe_n_o) else $error("input pin driven");
  AST_RX_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && par_wr |=> rxv_q) else $error("word lost");
  AST_PREADY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && psel && !penable |=> pready) else $error("no ready");
  COV_PAR: cover property (@(posedge clk_i) par_wr);
  COV_SER: cover property (@(posedge clk_i) ser_done);
  COV_DSI: cover property (@(posedge clk_i) kind == HIMS_DSI_M);
  COV_SER2L: cover property (@(posedge clk_i) kind == HIMS_SER2L);
  COV_RD: cover property (@(posedge clk_i) par_rd);

  // Pad taps stay quiet outside the link mode
  AST_HS_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && kind != HIMS_DSI_M |=> hs_clock_pair_o == 4'h0 && hs_lane0_pair_o == 8'h00)
    else $error("pad taps active outside link mode");

  // Lane zero follows the synchronised shared data pads one cycle later
  AST_LANE0_TAP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && kind == HIMS_DSI_M |=> hs_lane0_pair_o == $past({db_s[15:12], db_s[11:8]}))
    else $error("lane zero tap wrong");

  // A read strobe in a parallel mode turns the whole bus around
  AST_RD_DRIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && par_rd |=> !(|parallel_data_pins_oe_n_o))
    else $error("bus not driven on read");

  // Deselected, no serial frame finishing: no new word may appear, only a clear
  AST_CS_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && cs_n && !ser_done |=> !rxv_q || $past(rxv_q))
    else $error("word appeared while deselected");

  // Hardware reset pin blocks parallel capture
  AST_HWR_BLOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !hwr_n |-> !par_wr)
    else $error("write taken in pin reset");

  // A finished serial frame always raises the valid flag
  AST_SER_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && ser_done |=> rxv_q)
    else $error("serial word lost");

  // Parallel word keeps the sampled data/command level
  AST_PAR_DC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && par_wr |=> rx_q.is_data == $past(dc_sync_q))
    else $error("data command flag wrong");

  // Separate output pin stays low in the shared-pin variants
  AST_SOUT_SPLIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && !split |=> !serial_read_out_o)
    else $error("serial out driven in shared mode");

  // Separate output pin carries the falling-edge bit
  AST_SOUT_COPY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && split |=> serial_read_out_o == $past(sout_q))
    else $error("serial out not the shifted bit");

  // Four-line codes decode to the eight-bit serial port
  AST_KIND_SER4: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    strap == `HIMS_S4_BIDIR || strap == `HIMS_S4_SPLIT |-> kind == HIMS_SER4)
    else $error("four-line code misdecoded");

  // Split three-line code decodes to the nine-bit serial port
  AST_KIND_SER3: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    strap == `HIMS_S3_SPLIT |-> kind == HIMS_SER3)
    else $error("three-line code misdecoded");

  // Reserved codes drive neither the parallel bus nor the serial data pin
  AST_NONE_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && kind == HIMS_NONE |=> serial_data_oe_n_o && (&parallel_data_pins_oe_n_o))
    else $error("pins driven on reserved code");

  // Two-lane select only applies to the shared three-line code
  AST_TWO_LANE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    kind == HIMS_SER2L |-> strap == `HIMS_S2LANE)
    else $error("two-lane mode on wrong code");

  // Outside serial modes the data pin is never driven
  AST_SER_OE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_en_i && kind != HIMS_SER3 && kind != HIMS_SER4 |=> serial_data_oe_n_o)
    else $error("serial pin driven outside serial mode");
endmodule

// *** hims_host_model.sv ***
module hims_host_model (
  output logic sclk_o,
  output logic sda_o,
  output logic wr_o,
  output logic cs_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle: clock stands still low, write pin high, deselected
  initial begin
    sclk_o = 1'b0;
    sda_o  = 1'b0;
    wr_o   = 1'b1;
    cs_n_o = 1'b1;
  end
  // One frame, msb first; data only moves while the clock is low
  task automatic send(input logic [8:0] bits, input int n, input logic dc, input logic sel);
    #37 cs_n_o = ~sel;
    #62.5;
    for (int i = n - 1; i >= 0; i--) begin
      sda_o = bits[i];
      wr_o  = (i == 0) ? dc : 1'b1;
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    // Released line flips so a stale bit cannot pass for a good one
    sda_o = ~sda_o;
    wr_o  = 1'b1;
    #62.5 cs_n_o = 1'b1;
  endtask
endmodule

// *** tb.sv ***
`include "hims_defines.svh"
module tb
  import hims_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hw_reset_low_i = 1'b1;
  logic [3:0]  straps = 4'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk;
  logic        sda_m;
  logic        wr_m;
  logic        cs_n_m;
  logic        sda_d;
  logic        sda_oe_n;
  logic        sync_o;
  logic [17:0] db = 18'h00000;
  logic        wr_t = 1'b1;
  logic        rd_t = 1'b1;
  logic        cs_t = 1'b1;
  logic [17:0] par_do;
  logic [17:0] par_oe_n;
  logic [7:0]  hs_l0;
  // Bench strobes merge with the serial host's idle-high pins
  wire         wr_w = wr_m & wr_t;
  wire         cs_w = cs_n_m & cs_t;
  int          errors = 0;
  int          tests_run = 0;
  // Bidirectional data wire: device wins while its enable is low
  wire         sda_w = sda_oe_n ? sda_m : sda_d;

  always #50 clk_i = ~clk_i;

  hims_host_model hims_host_model_inst (.sclk_o(sclk), .sda_o(sda_m), .wr_o(wr_m), .cs_n_o(cs_n_m));

  hims_top hims_top_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .hw_reset_low_i(hw_reset_low_i),
    .interface_select_straps_i(straps), .chip_select_low_i(cs_w), .dc_or_serial_clock_pin_i(sclk),
    .read_strobe_low_i(rd_t), .write_strobe_pin_i(wr_w), .parallel_data_pins_i(db),
    .parallel_data_pins_o(par_do), .parallel_data_pins_oe_n_o(par_oe_n), .serial_data_i(sda_w),
    .serial_data_o(sda_d), .serial_data_oe_n_o(sda_oe_n), .serial_read_out_o(),
    .frame_sync_pulse_out_o(sync_o), .hs_clock_pair_o(), .hs_lane0_pair_o(hs_l0),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic test_done();
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      test_done();
    end
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(what, exp & m, rd & m);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  // Straps pass a two-flop synchroniser, frames cross from the link clock
  task automatic frame(input logic [3:0] code, input logic [8:0] bits, input int n, input logic dc,
                       input logic sel, input logic [18:0] exp, input logic ok);
    straps <= code;
    repeat (4) @(posedge clk_i);
    hims_host_model_inst.send(bits, n, dc, sel);
    repeat (12) @(posedge clk_i);
    rchk("stat valid", `HIMS_REG_STAT, {31'h0, ok}, 32'h1);
    if (ok) begin
      rchk("rx word", `HIMS_REG_RXW, {13'h0, exp}, 32'h7FFFF);
      rchk("stat cleared", `HIMS_REG_STAT, 32'h0, 32'h1);
    end
  endtask

  task automatic t_reset();
    chk("sync out", 32'h0, {31'h0, sync_o});
    rchk("ctrl", `HIMS_REG_CTRL, {30'h0, `HIMS_RESET_CTRL}, 32'h3);
  endtask

  task automatic t_modes();
    hims_kind_t k;
    for (int c = 0; c < 16; c++) begin
      case (4'(c))
        4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: k = HIMS_PAR;
        4'h4: k = HIMS_DSI_M;
        4'h5, 4'hD: k = HIMS_SER3;
        4'h6, 4'hE: k = HIMS_SER4;
        default: k = HIMS_NONE;
      endcase
      straps <= 4'(c);
      repeat (4) @(posedge clk_i);
      rchk("mode", `HIMS_REG_MODE, {25'h0, k, 4'(c)}, 32'h7F);
    end
    straps <= 4'h5;
    repeat (4) @(posedge clk_i);
    wr(`HIMS_REG_CTRL, 32'h2);
    rchk("two lane mode", `HIMS_REG_MODE, {25'h0, HIMS_SER2L, 4'h5}, 32'h7F);
    wr(`HIMS_REG_CTRL, 32'h0);
  endtask

  task automatic t_sync();
    logic [31:0] rd;
    logic        err;
    wr(`HIMS_REG_CTRL, 32'h1);
    repeat (3) @(posedge clk_i);
    chk("sync high", 32'h1, {31'h0, sync_o});
    wr(`HIMS_REG_CTRL, 32'h0);
    repeat (3) @(posedge clk_i);
    chk("sync low", 32'h0, {31'h0, sync_o});
    apb(1'b0, 12'h014, 32'h0, rd, err);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, `HIMS_REG_MODE, 32'h0, rd, err);
    chk("mapped err", 32'h0, {31'h0, err});
  endtask

  task automatic t_serial();
    for (int d = 0; d < 2; d++) begin
      frame(4'h6, 9'h0A5, 8, d[0], 1'b1, {d[0], 18'h000A5}, 1'b1);
      frame(4'hD, {d[0], 8'h3C}, 9, 1'b1, 1'b1, {d[0], 18'h0003C}, 1'b1);
    end
  endtask

  task automatic t_block();
    frame(4'h6, 9'h05A, 8, 1'b1, 1'b0, 19'h0, 1'b0);
    hw_reset_low_i <= 1'b0;
    frame(4'h6, 9'h05A, 8, 1'b1, 1'b1, 19'h0, 1'b0);
    hw_reset_low_i <= 1'b1;
    frame(4'h6, 9'h0C3, 8, 1'b0, 1'b1, {1'b0, 18'h000C3}, 1'b1);
  endtask

  // One parallel word per code; data/command pin idles low, so a command
  task automatic t_par(input logic [3:0] code, input logic [17:0] exp);
    straps <= code;
    cs_t   <= 1'b0;
    db     <= 18'h2A5C3;
    repeat (4) @(posedge clk_i);
    wr_t <= 1'b0;
    repeat (3) @(posedge clk_i);
    wr_t <= 1'b1;
    repeat (6) @(posedge clk_i);
    rchk("par word", `HIMS_REG_RXW, {13'h0, 1'b0, exp}, 32'h7FFFF);
    cs_t <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic t_pins();
    t_par(4'h0, 18'h000C3);
    t_par(4'h8, 18'h0A9E1);
    t_par(4'hB, 18'h00152);
    wr(`HIMS_REG_TXW, 32'h5A);
    cs_t <= 1'b0;
    rd_t <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("par oe_n", 32'h0, {14'h0, par_oe_n});
    chk("par out", 32'h5A, {14'h0, par_do});
    rd_t <= 1'b1;
    cs_t <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("par release", 32'h3FFFF, {14'h0, par_oe_n});
    straps <= 4'h4;
    repeat (5) @(posedge clk_i);
    chk("lane0 tap", 32'hA5, {24'h0, hs_l0});
    wr(`HIMS_REG_TXW, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_modes();
    t_sync();
    t_serial();
    t_block();
    t_pins();
    test_done();
  end
endmodule
